/* File: timer_pkg.sv */
// Purpose: shared constants and types for the standard timer mode logic
// Assumes: 20 MHz system clock, timer counts one step per timer clock tick
// Notes:   word-wide registers on classic Wishbone, data in the low bits
package timer_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ctrl0_addr   = 8'h00; // run bit
  localparam logic [7:0] ctrl1_addr   = 8'h04; // timer_control_one
  localparam logic [7:0] count_addr   = 8'h08; // counter, read only
  localparam logic [7:0] cmp_a_addr   = 8'h0C; // compare_a_value
  localparam logic [7:0] cmp_p_addr   = 8'h10; // compare_p_value
  localparam logic [7:0] flags_addr   = 8'h14; // flags, write one to clear
  localparam logic [7:0] stim_addr    = 8'h18; // trigger enable

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int run_pos      = 0;
  localparam int trig_en_pos  = 0;
  localparam int flag_a_pos   = 0;
  localparam int flag_p_pos   = 1;
  localparam int flag_cap_pos = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  ctrl1_rst = 8'h00;
  localparam logic [15:0] cmp_a_rst = 16'h0000;
  localparam logic [7:0]  cmp_p_rst = 8'h00;

  // operating modes held in mode_select_hi/lo
  typedef enum logic [1:0] {
    mode_compare = 2'b00,
    mode_capture = 2'b01,
    mode_pwm     = 2'b10,
    mode_counter = 2'b11
  } mode_e;

  // output function codes
  localparam logic [1:0] fn_zero = 2'b00; // no change / force inactive / rising
  localparam logic [1:0] fn_one  = 2'b01; // low / force active / falling
  localparam logic [1:0] fn_two  = 2'b10; // high / pwm / both edges
  localparam logic [1:0] fn_three = 2'b11; // toggle / single pulse / no capture

  // timer_control_one layout
  typedef struct packed {
    mode_e      mode;            // mode_select_hi, mode_select_lo
    logic [1:0] out_fn;          // output_function_hi, output_function_lo
    logic       output_initial;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_select;
  } ctrl1_s;

  // pin group facing the outside
  typedef struct packed {
    logic out;    // timer output level
    logic out_en; // high while the pin is driven
  } pin_out_s;

endpackage

/* File: standard_timer.sv */
// Purpose: 16-bit standard timer with compare, counter, pwm, pulse and capture modes
// Assumes: tick is a one-cycle timer clock enable from the clock selector
// Notes:   pins from outside pass two flip-flops before edge detection
//          comparators fire on the count about to be reached, so periods are exact
//
// Notes on behaviour
// - mode 00 runs counter, three clear sources
// - clear-select low: clear on p, both flags
// - clear-select high: clear on a, a flag only
// - output changes only on a match or a run rise
// - function zero leaves output unchanged
// - run rising edge loads initial output level
// - counter mode like compare, pin released
// - swap low: period p times 256, duty a
// - swap high: period a, duty p times 256
// - duty at or above period: full active
// - pwm raises a and p flags on matches
// - forced levels keep counting and flags running
// - initial bit sets polarity, invert bit inverts
// - run rise or trigger edge starts pulse
// - run clear or a match ends pulse
// - pulse counter zeroed only on run rise
// - capture edge latches counter into a
// - capture counter wraps on p match
// - function three disables capture, counter runs
// - compare functions: none, low, high, toggle
// - capture edges: rising, falling, both, none
// - p compares with counter high byte only
`timescale 1ns/1ps
`default_nettype none

module standard_timer (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              tick,
  input  wire logic              trigger_pin,
  input  wire logic              capture_pin,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output timer_pkg::pin_out_s    pin_o,
  output logic                   match_a_flag,
  output logic                   match_p_flag
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  timer_pkg::ctrl1_s ctrl_r;
  logic              run_bit_r;
  logic              run_d_r;
  logic              trig_en_r;
  logic [15:0]       count_r;
  logic [15:0]       cmp_a_r;
  logic [7:0]        cmp_p_r;
  logic              flag_a_r;
  logic              flag_p_r;
  logic              flag_cap_r;
  logic              out_r;
  logic [2:0]        trig_sync_r;
  logic [2:0]        cap_sync_r;

  logic              bus_req;
  logic              wr;
  logic              run_rise;
  logic              trig_rise;
  logic              cap_edge;
  logic              do_capture;
  logic              hit_a;
  logic              hit_p;
  logic              hit_ovf;
  logic              clr_cnt;
  logic              set_a;
  logic              set_p;
  logic              pulse_stop;
  logic              pwm_lvl;
  logic [16:0]       period;
  logic [16:0]       duty;
  logic              wr_run;
  logic              wr_run_val;
  logic [15:0]       count_step;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------

  // two stages then an edge stage; stage 0 feeds stage 1 only
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_sync_r <= 3'h0;
      cap_sync_r  <= 3'h0;
    end else begin
      trig_sync_r <= {trig_sync_r[1:0], trigger_pin};
      cap_sync_r  <= {cap_sync_r[1:0], capture_pin};
    end
  end

  assign trig_rise = trig_sync_r[1] & ~trig_sync_r[2];

  // capture edge selection by output function
  always_comb begin
    case (ctrl_r.out_fn)
      timer_pkg::fn_zero: cap_edge = cap_sync_r[1] & ~cap_sync_r[2];
      timer_pkg::fn_one:  cap_edge = ~cap_sync_r[1] & cap_sync_r[2];
      timer_pkg::fn_two:  cap_edge = cap_sync_r[1] ^ cap_sync_r[2];
      default:            cap_edge = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // comparators and clear logic
  // ---------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr      = bus_req & wb_we_i & ~wb_ack_o;
  assign wr_run  = wr & (wb_adr_i == timer_pkg::ctrl0_addr) & wb_sel_i[0];
  assign wr_run_val = wb_dat_i[timer_pkg::run_pos];

  // matches look at the value the counter is about to take, so a clear
  // lands on that value and the period is exactly the compare value;
  // p = 0 then matches on the wrap from all ones, the overflow case
  assign count_step = count_r + 16'h0001;

  // no match in the cycle that the run rise zeroes the counter, so a
  // stale count from the last run cannot raise a flag or end a pulse
  assign hit_a   = run_bit_r & run_d_r & tick & (count_step == cmp_a_r);
  assign hit_p   = run_bit_r & run_d_r & tick & (count_step[15:8] == cmp_p_r)
                 & (count_r[15:8] != cmp_p_r);
  assign hit_ovf = run_bit_r & run_d_r & tick & (count_r == 16'hFFFF) & (cmp_p_r == 8'h00);
  assign run_rise = run_bit_r & ~run_d_r;

  assign do_capture = (ctrl_r.mode == timer_pkg::mode_capture) & run_bit_r & cap_edge;
  assign pulse_stop = (ctrl_r.mode == timer_pkg::mode_pwm)
                    & (ctrl_r.out_fn == timer_pkg::fn_three) & hit_a;

  // pwm period and duty from the swap bit, p scaled by 256
  always_comb begin
    if (ctrl_r.period_duty_swap) begin
      period = {1'b0, cmp_a_r};
      duty   = (cmp_p_r == 8'h00) ? 17'h10000 : {1'b0, cmp_p_r, 8'h00};
    end else begin
      period = (cmp_p_r == 8'h00) ? 17'h10000 : {1'b0, cmp_p_r, 8'h00};
      duty   = {1'b0, cmp_a_r};
    end
    pwm_lvl = ({1'b0, count_r} < duty) | (duty >= period);
  end

  // clear and flag selection per mode
  always_comb begin
    clr_cnt = 1'b0;
    set_a   = 1'b0;
    set_p   = 1'b0;
    case (ctrl_r.mode)
      timer_pkg::mode_compare, timer_pkg::mode_counter: begin
        if (ctrl_r.clear_select) begin
          clr_cnt = hit_a;
          set_a   = hit_a;
        end else begin
          clr_cnt = hit_p | hit_ovf;
          set_a   = hit_a;
          set_p   = hit_p;
        end
      end
      timer_pkg::mode_pwm: begin
        if (ctrl_r.out_fn == timer_pkg::fn_three) begin
          set_a = hit_a;
        end else begin
          clr_cnt = ctrl_r.period_duty_swap ? hit_a : hit_p;
          set_a   = hit_a;
          set_p   = hit_p;
        end
      end
      default: begin
        clr_cnt = hit_p;
        set_p   = hit_p;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------

  // zeroed on run rise; otherwise counts ticks, wraps on clear
  // a stopped counter keeps its value until the next run rise
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= 16'h0000;
    end else if (run_rise) begin
      count_r <= 16'h0000;
    end else if (run_bit_r & tick) begin
      count_r <= clr_cnt ? 16'h0000 : count_step;
    end
  end

  // ---------------------------------------------------------------
  // run bit and trigger
  // ---------------------------------------------------------------

  // software writes, trigger edge sets in pulse mode, a match clears
  // the match stop wins over a bus write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      run_bit_r <= 1'b0;
      run_d_r   <= 1'b0;
    end else begin
      run_d_r <= run_bit_r;
      if (pulse_stop) begin
        run_bit_r <= 1'b0;
      end else if (wr_run) begin
        run_bit_r <= wr_run_val;
      end else if (trig_en_r & trig_rise & (ctrl_r.mode == timer_pkg::mode_pwm)
                   & (ctrl_r.out_fn == timer_pkg::fn_three)) begin
        run_bit_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // output pin
  // ---------------------------------------------------------------

  // compare mode level: initial on run rise, then match action
  always_ff @(posedge clk) begin
    if (rst) begin
      out_r <= 1'b0;
    end else if (run_rise) begin
      out_r <= ctrl_r.output_initial;
    end else if ((ctrl_r.mode == timer_pkg::mode_compare) & set_a) begin
      case (ctrl_r.out_fn)
        timer_pkg::fn_zero: out_r <= out_r;
        timer_pkg::fn_one:  out_r <= 1'b0;
        timer_pkg::fn_two:  out_r <= 1'b1;
        default:            out_r <= ~out_r;
      endcase
    end
  end

  // final pin level per mode; in pwm mode the active level comes from the initial bit
  always_comb begin
    pin_o.out    = 1'b0;
    pin_o.out_en = 1'b0;
    case (ctrl_r.mode)
      timer_pkg::mode_compare: begin
        pin_o.out    = out_r ^ ctrl_r.output_invert;
        pin_o.out_en = 1'b1;
      end
      timer_pkg::mode_pwm: begin
        pin_o.out_en = 1'b1;
        case (ctrl_r.out_fn)
          timer_pkg::fn_zero:  pin_o.out = ~ctrl_r.output_initial;
          timer_pkg::fn_one:   pin_o.out = ctrl_r.output_initial;
          timer_pkg::fn_two:   pin_o.out = ~(pwm_lvl & run_bit_r) ^ ctrl_r.output_initial;
          default:             pin_o.out = ~run_bit_r ^ ctrl_r.output_initial;
        endcase
        pin_o.out = pin_o.out ^ ctrl_r.output_invert;
      end
      default: begin
        pin_o.out    = 1'b0;
        pin_o.out_en = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------

  // sticky, write one to clear; a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_a_r   <= 1'b0;
      flag_p_r   <= 1'b0;
      flag_cap_r <= 1'b0;
    end else begin
      if (set_a) begin
        flag_a_r <= 1'b1;
      end else if (wr & (wb_adr_i == timer_pkg::flags_addr) & wb_sel_i[0]
                   & wb_dat_i[timer_pkg::flag_a_pos]) begin
        flag_a_r <= 1'b0;
      end
      if (set_p) begin
        flag_p_r <= 1'b1;
      end else if (wr & (wb_adr_i == timer_pkg::flags_addr) & wb_sel_i[0]
                   & wb_dat_i[timer_pkg::flag_p_pos]) begin
        flag_p_r <= 1'b0;
      end
      if (do_capture) begin
        flag_cap_r <= 1'b1;
      end else if (wr & (wb_adr_i == timer_pkg::flags_addr) & wb_sel_i[0]
                   & wb_dat_i[timer_pkg::flag_cap_pos]) begin
        flag_cap_r <= 1'b0;
      end
    end
  end

  assign match_a_flag = flag_a_r;
  assign match_p_flag = flag_p_r;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------

  // control and compare values; capture overwrites compare a
  // compare a takes byte lanes 0 and 1; other registers use lane 0 only
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r    <= timer_pkg::ctrl1_s'(timer_pkg::ctrl1_rst);
      cmp_a_r   <= timer_pkg::cmp_a_rst;
      cmp_p_r   <= timer_pkg::cmp_p_rst;
      trig_en_r <= 1'b0;
    end else begin
      if (wr & (wb_adr_i == timer_pkg::ctrl1_addr) & wb_sel_i[0]) begin
        ctrl_r <= timer_pkg::ctrl1_s'(wb_dat_i[7:0]);
      end
      if (do_capture) begin
        cmp_a_r <= count_r;
      end else if (wr & (wb_adr_i == timer_pkg::cmp_a_addr)) begin
        if (wb_sel_i[0]) cmp_a_r[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) cmp_a_r[15:8] <= wb_dat_i[15:8];
      end
      if (wr & (wb_adr_i == timer_pkg::cmp_p_addr) & wb_sel_i[0]) begin
        cmp_p_r <= wb_dat_i[7:0];
      end
      if (wr & (wb_adr_i == timer_pkg::stim_addr) & wb_sel_i[0]) begin
        trig_en_r <= wb_dat_i[timer_pkg::trig_en_pos];
      end
    end
  end

  // ---------------------------------------------------------------
  // wishbone answer
  // ---------------------------------------------------------------

  // one-cycle ack, read data registered; unmapped reads give zero
  // ack drops in the cycle after it is given, so a held request is taken again every second cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (wb_adr_i == timer_pkg::ctrl0_addr) begin
        wb_dat_o <= {31'h0, run_bit_r};
      end else if (wb_adr_i == timer_pkg::ctrl1_addr) begin
        wb_dat_o <= {24'h0, ctrl_r};
      end else if (wb_adr_i == timer_pkg::count_addr) begin
        wb_dat_o <= {16'h0, count_r};
      end else if (wb_adr_i == timer_pkg::cmp_a_addr) begin
        wb_dat_o <= {16'h0, cmp_a_r};
      end else if (wb_adr_i == timer_pkg::cmp_p_addr) begin
        wb_dat_o <= {24'h0, cmp_p_r};
      end else if (wb_adr_i == timer_pkg::flags_addr) begin
        wb_dat_o <= {29'h0, flag_cap_r, flag_p_r, flag_a_r};
      end else if (wb_adr_i == timer_pkg::stim_addr) begin
        wb_dat_o <= {31'h0, trig_en_r};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

/* File: standard_timer_checker.sv */
// Purpose: concurrent checks on the standard timer ports
// Assumes: control writes take effect at the edge that the bus request is taken
// Notes:   mode and run are shadowed from bus writes, so no internal state is seen
`timescale 1ns/1ps
`default_nettype none

module standard_timer_checker (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic                wb_ack_o,
  input wire timer_pkg::pin_out_s pin_o,
  input wire logic                match_a_flag,
  input wire logic                match_p_flag
);
  timer_pkg::ctrl1_s cfg_r;
  logic              run_r;
  logic              take;
  logic              clr_a;
  logic              clr_p;

  // a write request on lane zero, at the edge where it is taken
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign clr_a = take && wb_adr_i == timer_pkg::flags_addr && wb_dat_i[timer_pkg::flag_a_pos];
  assign clr_p = take && wb_adr_i == timer_pkg::flags_addr && wb_dat_i[timer_pkg::flag_p_pos];

  // shadow of control one and run bit, updated at the same edge as the design
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= timer_pkg::ctrl1_s'(timer_pkg::ctrl1_rst);
      run_r <= 1'b0;
    end else if (take && wb_adr_i == timer_pkg::ctrl1_addr) begin
      cfg_r <= timer_pkg::ctrl1_s'(wb_dat_i[7:0]);
    end else if (take && wb_adr_i == timer_pkg::ctrl0_addr) begin
      run_r <= wb_dat_i[timer_pkg::run_pos];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  pin_release_a: assert property (
    pin_o.out_en == (cfg_r.mode inside {timer_pkg::mode_compare, timer_pkg::mode_pwm}))
    else $error("output enable does not follow mode");
  run_init_a: assert property (
    take && wb_adr_i == timer_pkg::ctrl0_addr && wb_dat_i[0] && !run_r
    && cfg_r.mode == timer_pkg::mode_compare && !cfg_r.output_invert
    |-> ##2 pin_o.out == cfg_r.output_initial)
    else $error("run rise did not load initial level");
  forced_level_a: assert property (
    run_r && cfg_r.mode == timer_pkg::mode_pwm && !cfg_r.out_fn[1] && !cfg_r.output_invert
    |-> pin_o.out == (cfg_r.out_fn[0] ~^ cfg_r.output_initial))
    else $error("forced pwm level wrong");
  no_p_flag_a: assert property (
    run_r && cfg_r.clear_select && $stable(cfg_r)
    && cfg_r.mode inside {timer_pkg::mode_compare, timer_pkg::mode_counter}
    |-> !$rose(match_p_flag))
    else $error("p flag raised with clear on a");
  sticky_a_a: assert property ($fell(match_a_flag) && !$past(rst) |-> $past(clr_a))
    else $error("a flag fell without a clear");
  sticky_p_a: assert property ($fell(match_p_flag) && !$past(rst) |-> $past(clr_p))
    else $error("p flag fell without a clear");
endmodule

bind standard_timer standard_timer_checker mode_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .pin_o, .match_a_flag,
  .match_p_flag);

`default_nettype wire

/* File: pin_source.sv */
// Purpose: outside pulse sources on the trigger and capture pins
// Assumes: the bench asks for pin levels
// Notes:   each pin follows its request after lag clocks, a slow source
`timescale 1ns/1ps
`default_nettype none

module pin_source #(
  parameter int lag = 4
) (
  input  wire logic clk,
  input  wire logic cap_req,
  input  wire logic trig_req,
  output logic      capture_pin,
  output logic      trigger_pin
);
  logic [lag-1:0] cap_r  = '0;
  logic [lag-1:0] trig_r = '0;

  // delay lines; levels last many clocks so the synchroniser sees every edge
  always_ff @(posedge clk) begin
    cap_r  <= {cap_r[lag-2:0], cap_req};
    trig_r <= {trig_r[lag-2:0], trig_req};
  end
  assign capture_pin = cap_r[lag-1];
  assign trigger_pin = trig_r[lag-1];
endmodule

`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for the standard timer modes
// Assumes: one-cycle bus ack, tick held high so the timer counts at clk rate
// Notes:   reads leave notes in a queue that a monitor retires on ack
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct packed {
    logic [31:0] m;
    logic [31:0] v;
  } note_s;
  logic                clk      = 1'b0;
  logic                rst      = 1'b1;
  logic                tick     = 1'b1;
  logic                cyc      = 1'b0;
  logic                we       = 1'b0;
  logic [7:0]          adr      = 8'h00;
  logic [31:0]         dat      = 32'h0;
  logic                cap_req  = 1'b0;
  logic                trig_req = 1'b0;
  logic [31:0]         dat_o;
  logic                ack, fa, fp, cap_pin, trig_pin, ex;
  timer_pkg::pin_out_s pin;
  note_s               q[$];
  note_s               nt;
  int                  bad_count = 0, n_checks = 0, seed = 78776, hi, w, k;
  logic [31:0]         r;
  logic [7:0]          pc [8] = '{8'hA8, 8'hAC, 8'hA8, 8'hAA, 8'h88, 8'h98, 8'hA9, 8'hA0};
  logic [15:0]         pa [8] = '{16'h0040, 16'h0040, 16'h0200, 16'h0080,
                                  16'h0040, 16'h0040, 16'h0040, 16'h0040};
  int                  ph [8] = '{128, 384, 512, 512, 0, 512, 128, 384};
  int                  pf [8] = '{3, 3, 2, 1, 3, 3, 3, 3};

  always #25 clk = ~clk;

  standard_timer uut (.clk, .rst, .tick, .trigger_pin(trig_pin), .capture_pin(cap_pin),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pin_o(pin), .match_a_flag(fa),
    .match_p_flag(fp));
  pin_source src (.clk, .cap_req, .trig_req, .capture_pin(cap_pin), .trigger_pin(trig_pin));

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  // one classic cycle; the note is retired by the monitor at the ack edge
  task automatic bus(input logic w_i, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] v);
    int n;
    q.push_back({m, v});
    @(posedge clk);
    cyc <= 1'b1;
    we  <= w_i;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 1, 0);
    cyc <= 1'b0;
  endtask

  task automatic setup(input logic [7:0] c, input logic [15:0] a, input logic [7:0] p,
                       input logic run);
    bus(1, timer_pkg::ctrl0_addr, 32'h0, 32'h0, 32'h0);
    bus(1, timer_pkg::flags_addr, 32'h7, 32'h0, 32'h0);
    bus(1, timer_pkg::ctrl1_addr, {24'h0, c}, 32'h0, 32'h0);
    bus(1, timer_pkg::cmp_a_addr, {16'h0, a}, 32'h0, 32'h0);
    bus(1, timer_pkg::cmp_p_addr, {24'h0, p}, 32'h0, 32'h0);
    bus(1, timer_pkg::ctrl0_addr, {31'h0, run}, 32'h0, 32'h0);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // monitor: compare read data with the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      if (nt.m != 32'h0) chk("read_data", nt.v, dat_o & nt.m);
    end
  end

  // watchdog cuts a hang short
  initial begin
    #2000000;
    bad_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) bus(0, 8'(a * 4), 32'h0, 32'hFFFFFFFF, 32'h0);
    r = $random(seed);
    bus(1, timer_pkg::cmp_a_addr, r, 32'h0, 32'h0);
    bus(0, timer_pkg::cmp_a_addr, 32'h0, 32'hFFFF, r & 32'hFFFF);
    bus(1, timer_pkg::cmp_p_addr, r, 32'h0, 32'h0);
    bus(0, timer_pkg::cmp_p_addr, 32'h0, 32'hFF, r & 32'hFF);
    bus(1, timer_pkg::ctrl1_addr, r, 32'h0, 32'h0);
    bus(0, timer_pkg::ctrl1_addr, 32'h0, 32'hFF, r & 32'hFF);
    bus(1, timer_pkg::count_addr, r, 32'h0, 32'h0);
    bus(0, timer_pkg::count_addr, 32'h0, 32'hFFFF, 32'h0);
    bus(1, 8'h1C, r, 32'h0, 32'h0);
    bus(0, 8'h1C, 32'h0, 32'hFFFFFFFF, 32'h0);
    // compare mode, every output function with both initial levels
    for (int f = 0; f < 4; f++) begin
      for (int i = 0; i < 2; i++) begin
        setup({2'b00, f[1:0], i[0], 3'b000}, 16'h0080, 8'h01, 1'b1);
        ex = (f == 0) ? i[0] : (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : !i[0];
        repeat (20) @(posedge clk);
        chk("cmp_init", i, pin.out);
        repeat (150) @(posedge clk);
        chk("cmp_out", ex, pin.out);
        chk("cmp_flag_a", 1, {fp, fa});
        repeat (130) @(posedge clk);
        chk("cmp_flag_p", 3, {fp, fa});
        chk("cmp_hold", ex, pin.out);
      end
    end
    setup(8'h01, 16'h0200, 8'h01, 1'b1);
    repeat (700) @(posedge clk);
    chk("clear_on_a", 1, {fp, fa});
    setup(8'hC0, 16'h0080, 8'h01, 1'b1);
    repeat (300) @(posedge clk);
    chk("counter_en", 0, pin.out_en);
    chk("counter_flags", 3, {fp, fa});
    // pwm table: polarity, invert, swap, full duty, forced levels
    for (int e = 0; e < 8; e++) begin
      setup(pc[e], pa[e], 8'h01, 1'b1);
      repeat (40) @(posedge clk);
      hi = 0;
      repeat (512) begin
        @(posedge clk);
        hi += pin.out;
      end
      chk("pwm_high", ph[e], hi);
      chk("pwm_flags", pf[e], {fp, fa});
    end
    // single pulse from the trigger pin, then from software
    bus(1, timer_pkg::stim_addr, 32'h1, 32'h0, 32'h0);
    setup(8'hBB, 16'h0040, 8'h00, 1'b0);
    trig_req <= 1'b1;
    k = 0;
    while (pin.out !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    w = 0;
    while (pin.out === 1'b1 && w < 200) begin
      @(posedge clk);
      w++;
    end
    chk("pulse_width", 1, w >= 63 && w <= 66);
    bus(0, timer_pkg::ctrl0_addr, 32'h0, 32'h1, 32'h0);
    chk("pulse_flags", 1, {fp, fa});
    trig_req <= 1'b0;
    bus(1, timer_pkg::ctrl0_addr, 32'h1, 32'h0, 32'h0);
    repeat (10) @(posedge clk);
    chk("sw_lead", 1, pin.out);
    bus(1, timer_pkg::ctrl0_addr, 32'h0, 32'h0, 32'h0);
    repeat (2) @(posedge clk);
    chk("sw_trail", 0, pin.out);
    // capture on each edge code
    for (int f = 0; f < 4; f++) begin
      setup({2'b01, f[1:0], 4'h0}, 16'h0000, 8'h01, 1'b1);
      cap_req <= 1'b1;
      repeat (12) @(posedge clk);
      bus(0, timer_pkg::flags_addr, 32'h0, 32'h4, (f == 0 || f == 2) ? 32'h4 : 32'h0);
      bus(1, timer_pkg::flags_addr, 32'h4, 32'h0, 32'h0);
      cap_req <= 1'b0;
      repeat (12) @(posedge clk);
      bus(0, timer_pkg::flags_addr, 32'h0, 32'h4, (f == 1 || f == 2) ? 32'h4 : 32'h0);
    end
    repeat (300) @(posedge clk);
    chk("capture_wrap", 1, fp);
    print_verdict();
  end
endmodule

`default_nettype wire
